// file: slec_classifier.sv
`timescale 1ns/100ps
`default_nettype none
`include "slec_defs.svh"

module slec_classifier
#(
    parameter longint unsigned ESTAB_CYCLES = `SLEC_ESTAB_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // own sent units and connection control
    input wire logic conn_start,
    input wire logic initiator,
    input wire logic sent_au1,
    input wire logic sent_au2,
    input wire logic sent_au3,
    input wire logic conn_close,
    // received unit with its check results
    input wire logic rx_valid,
    input wire slec_pkg::slec_rx_t rx,
    // internal fault events and peer release
    input wire logic key_missing,
    input wire logic key_fault,
    input wire logic feature_unsup,
    input wire logic peer_release,
    // implementation-specific error
    input wire logic impl_valid,
    input wire logic [7:0] impl_reason,
    input wire logic [7:0] impl_sub,
    // classified result
    output logic res_valid,
    output slec_pkg::slec_result_t res,
    output logic send_disc_unit,
    output logic safe_connect_ind,
    output logic [2:0] phase
);
    import slec_pkg::*;

    slec_phase_t ph_reg;
    slec_phase_t ph_next;
    logic connected_reg;
    logic connected_next;
    logic res_valid_next;
    slec_result_t res_next;
    logic conind_next;
    logic timeout;
    logic id_ok;

    // establishment supervision runs while waiting for the second, third or response unit
    wire logic timer_run = (ph_reg == SLEC_S_WAIT_AU2) || (ph_reg == SLEC_S_WAIT_AU3)
        || (ph_reg == SLEC_S_WAIT_AR);

    slec_estab_timer #(.CYCLES(ESTAB_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(timer_run),
        .expired(timeout)
    );

    slec_peer_match u_match (
        .id_known(rx.id_known),
        .peer_unknown(rx.peer_unknown),
        .id_in_list(rx.id_in_list),
        .id_ok(id_ok)
    );

    // received unit decode
    wire logic is_au1 = rx.kind == SLEC_U_AU1;
    wire logic is_au2 = rx.kind == SLEC_U_AU2;
    wire logic is_au3 = rx.kind == SLEC_U_AU3;
    wire logic is_ar = rx.kind == SLEC_U_AR;
    wire logic is_dt = rx.kind == SLEC_U_DT;
    wire logic is_di = rx.kind == SLEC_U_DI;
    wire logic is_auth = is_au1 || is_au2 || is_au3 || is_ar;
    // direction checked only after mac and not for first/disconnect units
    wire logic dir_checked = !(is_au1 || is_di);
    // initiator expects flag 1 on received units, responder expects 0
    wire logic dir_bad = dir_checked && (rx.dir_flag != initiator);
    wire logic seq_bad = ((ph_reg == SLEC_S_WAIT_AU2) && !is_au2)
        || ((ph_reg == SLEC_S_WAIT_AU3) && !is_au3)
        || ((ph_reg == SLEC_S_WAIT_AR) && !is_ar);
    wire logic replay = (ph_reg == SLEC_S_OPEN) && is_auth;
    wire logic rx_ok = rx_valid && !rx.len_err && !rx.mac_err && !dir_bad && !seq_bad
        && !rx.field_err && !(is_au1 && rx.au1_struct_err) && !(is_au2 && !id_ok);

    // actions
    localparam slec_action_t ACT_NONE = '{1'b0, 1'b0, 1'b0, 1'b0};
    localparam slec_action_t ACT_REJ = '{1'b0, 1'b0, 1'b0, 1'b1};
    localparam slec_action_t ACT_REP = '{1'b0, 1'b0, 1'b1, 1'b0};
    localparam slec_action_t ACT_DISC = '{1'b0, 1'b1, 1'b0, 1'b0};
    localparam slec_action_t ACT_TDISC = '{1'b1, 1'b0, 1'b0, 1'b0};

    // classification priority chain
    always_comb
    begin
        res_valid_next = 1'b1;
        res_next = '{`SLEC_UNKNOWN, `SLEC_UNKNOWN, ACT_DISC};
        if (key_missing)
            res_next = '{`SLEC_RSN_KEY, `SLEC_SUB_2, ACT_DISC};
        else if (key_fault)
            res_next = '{`SLEC_RSN_KEY, `SLEC_SUB_3, ACT_DISC};
        else if (feature_unsup)
            res_next = '{`SLEC_RSN_KEY, `SLEC_SUB_FEATURE, ACT_DISC};
        else if (timeout)
            res_next = '{`SLEC_RSN_TIMEOUT, `SLEC_SUB_3, ACT_DISC};
        else if (peer_release)
            res_next = '{`SLEC_RSN_NORMAL, `SLEC_SUB_NONE, ACT_DISC};
        else if (rx_valid && rx.len_err)
        begin
            // length first
            if (is_au1)
                res_next = '{`SLEC_RSN_LEN, `SLEC_SUB_1, ACT_REJ};
            else if (is_au2)
                res_next = '{`SLEC_RSN_LEN, `SLEC_SUB_2, ACT_DISC};
            else if (is_au3)
                res_next = '{`SLEC_RSN_LEN, `SLEC_SUB_3, ACT_TDISC};
            else if (is_dt)
                res_next = '{`SLEC_RSN_LEN, `SLEC_SUB_5, ACT_DISC};
            else if (is_ar)
                res_next = '{`SLEC_RSN_LEN, `SLEC_SUB_8, ACT_DISC};
        end
        else if (rx_valid && rx.mac_err)
        begin
            // mac second, so a corrupted flag shows here
            if (is_au2)
                res_next = '{`SLEC_RSN_AUTH, `SLEC_SUB_2, ACT_DISC};
            else if (is_au3)
                res_next = '{`SLEC_RSN_AUTH, `SLEC_SUB_3, ACT_TDISC};
            else if (is_ar)
                res_next = '{`SLEC_RSN_AUTH, `SLEC_SUB_4, ACT_DISC};
            else
                res_next = '{`SLEC_RSN_AUTH, `SLEC_SUB_1, ACT_REP};
        end
        else if (rx_valid && dir_bad)
        begin
            if (initiator)
                res_next = '{`SLEC_RSN_DIR, `SLEC_SUB_1, ACT_DISC};
            else if (connected_reg)
                res_next = '{`SLEC_RSN_DIR, `SLEC_SUB_2, ACT_DISC};
            else
                res_next = '{`SLEC_RSN_DIR, `SLEC_SUB_2, ACT_NONE};
        end
        else if (rx_valid && seq_bad)
        begin
            // sequence fourth, after direction
            if (ph_reg == SLEC_S_WAIT_AU2)
                res_next = '{`SLEC_RSN_SEQ, `SLEC_SUB_1, ACT_DISC};
            else if (ph_reg == SLEC_S_WAIT_AU3)
                res_next = '{`SLEC_RSN_SEQ, `SLEC_SUB_2, ACT_TDISC};
            else
                res_next = '{`SLEC_RSN_SEQ, `SLEC_SUB_3, ACT_DISC};
        end
        else if (rx_valid && replay)
            res_next = '{`SLEC_RSN_REPLAY, `SLEC_SUB_1, ACT_DISC};
        else if (rx_valid && is_au1 && rx.au1_struct_err)
            res_next = '{`SLEC_RSN_FIELD, `SLEC_SUB_5, ACT_REJ};
        else if (rx_valid && rx.field_err)
            res_next = '{`SLEC_RSN_FIELD, `SLEC_SUB_1, ACT_REJ};
        else if (rx_valid && is_au2 && !id_ok)
            res_next = '{`SLEC_RSN_FIELD, `SLEC_SUB_4, ACT_DISC};
        else if (impl_valid)
        begin
            // only 128 and up pass; reserved range becomes unknown
            if (impl_reason >= `SLEC_RSN_IMPL_LO)
                res_next = '{impl_reason, impl_sub, ACT_DISC};
            else
                res_next = '{`SLEC_UNKNOWN, `SLEC_UNKNOWN, ACT_DISC};
        end
        else
        begin
            res_valid_next = 1'b0;
            res_next = '{`SLEC_SUB_NONE, `SLEC_SUB_NONE, ACT_NONE};
        end
    end

    // connection phase tracking
    wire logic ends_conn = res_valid_next && (res_next.action.disc_ind
        || res_next.action.t_disc_req);
    always_comb
    begin
        ph_next = ph_reg;
        connected_next = connected_reg;
        conind_next = 1'b0;
        if (conn_close || ends_conn)
        begin
            ph_next = SLEC_S_IDLE;
            connected_next = 1'b0;
        end
        else if (conn_start)
            ph_next = SLEC_S_IDLE;
        else if (sent_au1)
            ph_next = SLEC_S_WAIT_AU2;
        else if (sent_au2)
            ph_next = SLEC_S_WAIT_AU3;
        else if (sent_au3)
            ph_next = SLEC_S_WAIT_AR;
        else if (rx_ok && ((ph_reg == SLEC_S_WAIT_AR && is_ar)
            || (ph_reg == SLEC_S_WAIT_AU3 && is_au3)))
        begin
            // responder opens on good third message, initiator on good response
            ph_next = SLEC_S_OPEN;
            connected_next = 1'b1;
            conind_next = 1'b1;
        end
    end

    // result and phase registers; result holds one cycle
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ph_reg <= SLEC_S_IDLE;
            connected_reg <= 1'b0;
            res_valid <= 1'b0;
            res <= '0;
            send_disc_unit <= 1'b0;
            safe_connect_ind <= 1'b0;
        end
        else
        begin
            ph_reg <= ph_next;
            connected_reg <= connected_next;
            res_valid <= res_valid_next;
            res <= res_next;
            send_disc_unit <= res_valid_next && res_next.action.t_disc_req;
            safe_connect_ind <= conind_next;
        end
    end

    assign phase = ph_reg;
endmodule : slec_classifier
`default_nettype wire

// file: slec_defs.svh
`ifndef SLEC_DEFS_SVH
`define SLEC_DEFS_SVH

// reason codes
`define SLEC_RSN_NORMAL 8'h00
`define SLEC_RSN_KEY 8'h03
`define SLEC_RSN_AUTH 8'h04
`define SLEC_RSN_REPLAY 8'h05
`define SLEC_RSN_DIR 8'h06
`define SLEC_RSN_TIMEOUT 8'h07
`define SLEC_RSN_FIELD 8'h08
`define SLEC_RSN_SEQ 8'h09
`define SLEC_RSN_LEN 8'h0A
`define SLEC_UNKNOWN 8'h7F
`define SLEC_RSN_RES_LO 8'h0B
`define SLEC_RSN_RES_HI 8'h7E
`define SLEC_RSN_IMPL_LO 8'h80

// sub-reason codes
`define SLEC_SUB_NONE 8'h00
`define SLEC_SUB_1 8'h01
`define SLEC_SUB_2 8'h02
`define SLEC_SUB_3 8'h03
`define SLEC_SUB_4 8'h04
`define SLEC_SUB_5 8'h05
`define SLEC_SUB_8 8'h08
`define SLEC_SUB_FEATURE 8'h1D

// establishment timer
`define SLEC_ESTAB_S 40
`define SLEC_CLK_HZ 40000000
`define SLEC_ESTAB_CYC (`SLEC_ESTAB_S * `SLEC_CLK_HZ)

`endif

// file: slec_pkg.sv
`default_nettype none
package slec_pkg;

    // kind of received safety unit
    typedef enum logic [2:0] {
        SLEC_U_AU1,
        SLEC_U_AU2,
        SLEC_U_AU3,
        SLEC_U_AR,
        SLEC_U_DT,
        SLEC_U_DI
    } slec_unit_t;

    // one-hot handling action, all zero when no action
    typedef struct packed {
        logic t_disc_req;
        logic disc_ind;
        logic report_ind;
        logic reject;
    } slec_action_t;

    // check results for one received unit
    typedef struct packed {
        slec_unit_t kind;
        logic len_err;
        logic mac_err;
        logic dir_flag;
        logic field_err;
        logic au1_struct_err;
        logic id_known;
        logic peer_unknown;
        logic id_in_list;
    } slec_rx_t;

    // classification result
    typedef struct packed {
        logic [7:0] reason;
        logic [7:0] sub_reason;
        slec_action_t action;
    } slec_result_t;

    // connection phase
    typedef enum logic [2:0] {
        SLEC_S_IDLE,
        SLEC_S_WAIT_AU2,
        SLEC_S_WAIT_AU3,
        SLEC_S_WAIT_AR,
        SLEC_S_OPEN
    } slec_phase_t;

endpackage : slec_pkg
`default_nettype wire

// file: slec_estab_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "slec_defs.svh"

module slec_estab_timer
#(
    parameter longint unsigned CYCLES = `SLEC_ESTAB_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    // status
    output logic expired
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic expired_next;
    wire logic at_end = (cnt_reg == 32'(CYCLES - 1));

    // counts while running, one-cycle pulse at the limit
    assign cnt_next = !run ? 32'h0000_0000 : (at_end ? cnt_reg : cnt_reg + 32'h0000_0001);
    assign expired_next = run && at_end && !expired;

    // timer state
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 32'h0000_0000;
            expired <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            expired <= expired_next;
        end
    end
endmodule : slec_estab_timer
`default_nettype wire

// file: slec_peer_match.sv
`timescale 1ns/100ps
`default_nettype none

module slec_peer_match
(
    // check inputs
    input wire logic id_known,
    input wire logic peer_unknown,
    input wire logic id_in_list,
    // result
    output logic id_ok
);
    // any listed peer is acceptable when the called peer was unknown
    assign id_ok = peer_unknown ? id_in_list : id_known;
endmodule : slec_peer_match
`default_nettype wire

// file: slec_classifier_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module slec_classifier_asserts
#(
    parameter longint unsigned ESTAB_CYCLES = 20
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // inputs watched
    input wire logic rx_valid,
    input wire slec_pkg::slec_rx_t rx,
    input wire logic key_missing,
    input wire logic key_fault,
    input wire logic feature_unsup,
    input wire logic peer_release,
    // outputs watched
    input wire logic res_valid,
    input wire slec_pkg::slec_result_t res,
    input wire logic send_disc_unit,
    input wire logic safe_connect_ind,
    input wire logic [2:0] phase
);
    import slec_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // a unit with no event of higher rank, timer idle
    wire logic hi_evt = key_missing || key_fault || feature_unsup;
    wire logic lone = rx_valid && phase == 3'h0 && !hi_evt && !peer_release;
    // result framing and coding
    clear_idle_a:
        assert property (!res_valid |-> res == '0)
        else $error("result left standing");
    one_hot_a:
        assert property (res_valid && {res.reason, res.sub_reason} != 16'h0602 |->
            $onehot(res.action))
        else $error("action not one-hot");
    disc_unit_a:
        assert property (send_disc_unit == (res_valid && res.action.t_disc_req))
        else $error("disconnect unit mismatch");
    key_miss_a:
        assert property (key_missing |=> res_valid && res == 20'h0_3024)
        else $error("missing key result wrong");
    reserved_a:
        assert property (res_valid |-> !(res.reason inside {[8'h0B:8'h7E]}))
        else $error("reserved reason produced");
    au3_len_a:
        assert property (lone && rx.kind == SLEC_U_AU3 && rx.len_err |=>
            res == 20'h0_a038 && send_disc_unit)
        else $error("third message length wrong");
    mac_rep_a:
        assert property (lone && rx.kind == SLEC_U_DT && !rx.len_err && rx.mac_err |=>
            res == 20'h0_4012)
        else $error("mac report wrong");
    release_a:
        assert property (peer_release && !hi_evt && phase == 3'h0 |=> res == 20'h0_0004)
        else $error("release result wrong");
    // main scenarios reached
    cover property (send_disc_unit);
    cover property (safe_connect_ind);
    cover property (res_valid && res.reason == 8'h07);
endmodule : slec_classifier_asserts
bind slec_classifier slec_classifier_asserts #(.ESTAB_CYCLES(ESTAB_CYCLES)) chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx(rx),
    .key_missing(key_missing), .key_fault(key_fault), .feature_unsup(feature_unsup),
    .peer_release(peer_release), .res_valid(res_valid), .res(res),
    .send_disc_unit(send_disc_unit), .safe_connect_ind(safe_connect_ind), .phase(phase));
`default_nettype wire

// file: slec_peer.sv
`timescale 1ns/100ps
`default_nettype none
module slec_peer
(
    // clock
    input wire logic sys_clk,
    // received unit toward the classifier
    output logic rx_valid,
    output slec_pkg::slec_rx_t rx
);
    import slec_pkg::*;
    // quiet bus at start
    initial
    begin
        rx_valid = 1'h0;
        rx = '0;
    end
    // one unit after some idle cycles; released bus shows the inverse
    task automatic send(input slec_rx_t u, input int gap);
        repeat (gap) @(negedge sys_clk);
        rx_valid = 1'h1;
        rx = u;
        @(negedge sys_clk);
        rx_valid = 1'h0;
        rx = ~u;
    endtask : send
endmodule : slec_peer
`default_nettype wire

// file: slec_classifier_tb.sv
`timescale 1ns/100ps
`default_nettype none
module slec_classifier_tb;
    import slec_pkg::*;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic initiator = 1'h0;
    logic impl_valid = 1'h0;
    logic [4:0] ctl = '0;
    logic [3:0] evt = '0;
    logic [7:0] impl_reason = '0;
    logic [7:0] impl_sub = '0;
    logic rx_valid;
    logic res_valid;
    logic send_disc_unit;
    logic safe_connect_ind;
    logic [2:0] phase;
    slec_rx_t rx;
    slec_result_t res;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    // unit kind, flags, expected reason, sub-reason, action
    localparam logic [30:0] ROWS [17] = '{
        {SLEC_U_AU1, 8'ha4, 20'h0_a011}, {SLEC_U_AU2, 8'ha4, 20'h0_a024},
        {SLEC_U_AU3, 8'ha4, 20'h0_a038}, {SLEC_U_DT, 8'ha4, 20'h0_a054},
        {SLEC_U_AR, 8'ha4, 20'h0_a084}, {SLEC_U_DT, 8'h64, 20'h0_4012},
        {SLEC_U_AU2, 8'h64, 20'h0_4024}, {SLEC_U_AU3, 8'h64, 20'h0_4038},
        {SLEC_U_AR, 8'h64, 20'h0_4044}, {SLEC_U_AU3, 8'hf4, 20'h0_a038},
        {SLEC_U_DT, 8'h44, 20'h0_4012}, {SLEC_U_DT, 8'h04, 20'h0_6014},
        {SLEC_U_AU1, 8'h04, 20'h0_0000}, {SLEC_U_DI, 8'h04, 20'h0_0000},
        {SLEC_U_DT, 8'h34, 20'h0_8011}, {SLEC_U_AU1, 8'h2c, 20'h0_8051},
        {SLEC_U_DT, 8'h24, 20'h0_6020}};
    always #12.5 sys_clk = ~sys_clk;
    slec_peer peer (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx(rx));
    slec_classifier #(.ESTAB_CYCLES(20)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .conn_start(ctl[4]), .initiator(initiator),
        .sent_au1(ctl[0]), .sent_au2(ctl[1]), .sent_au3(ctl[2]), .conn_close(ctl[3]),
        .rx_valid(rx_valid), .rx(rx), .key_missing(evt[3]), .key_fault(evt[2]),
        .feature_unsup(evt[1]), .peer_release(evt[0]), .impl_valid(impl_valid),
        .impl_reason(impl_reason), .impl_sub(impl_sub), .res_valid(res_valid), .res(res),
        .send_disc_unit(send_disc_unit), .safe_connect_ind(safe_connect_ind), .phase(phase));
    // verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic check(string n, logic [20:0] s, logic [20:0] e);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // one-cycle event pulse
    task automatic ev(logic [3:0] e);
        evt = e;
        @(negedge sys_clk);
        evt = '0;
    endtask : ev
    // control pulse, then a quiet cycle
    task automatic go(logic [4:0] c);
        ctl = c;
        @(negedge sys_clk);
        ctl = '0;
        @(negedge sys_clk);
    endtask : go
    // result against expectation, then a quiet cycle
    task automatic seen(string n, logic [19:0] e);
        check(n, {res_valid, res}, {|e, e});
        check("disc unit", 21'(send_disc_unit), 21'(e[3]));
        @(negedge sys_clk);
    endtask : seen
    task automatic t_events();
        ev(4'h8);
        seen("key missing", 20'h0_3024);
        ev(4'h4);
        seen("key fault", 20'h0_3034);
        ev(4'h2);
        seen("feature", 20'h0_31d4);
        ev(4'h1);
        seen("release", 20'h0_0004);
        ev(4'hc);
        seen("two events", 20'h0_3024);
    endtask : t_events
    task automatic t_table();
        initiator = 1'h1;
        for (int i = 0; i < 17; i++)
        begin
            if (i == 16)
                initiator = 1'h0;
            peer.send(ROWS[i][30:20], 0);
            seen("unit", ROWS[i][19:0]);
        end
    endtask : t_table
    task automatic t_setup();
        initiator = 1'h1;
        go(5'h10);
        go(5'h01);
        peer.send({SLEC_U_AU2, 8'h23}, 3);
        seen("listed peer", 20'h0);
        go(5'h04);
        peer.send({SLEC_U_AR, 8'h24}, 0);
        check("connect", 21'(safe_connect_ind), 21'h1);
        check("phase open", 21'(phase), 21'h4);
        seen("response", 20'h0);
        peer.send({SLEC_U_AU2, 8'h24}, 0);
        seen("replay", 20'h0_5014);
        initiator = 1'h0;
        go(5'h10);
        go(5'h02);
        peer.send({SLEC_U_AU3, 8'h04}, 0);
        seen("third", 20'h0);
        peer.send({SLEC_U_DT, 8'h24}, 0);
        seen("flag open", 20'h0_6024);
    endtask : t_setup
    task automatic t_seq();
        initiator = 1'h1;
        go(5'h10);
        go(5'h01);
        check("phase wait", 21'(phase), 21'h1);
        peer.send({SLEC_U_DT, 8'h24}, 0);
        seen("not second", 20'h0_9014);
        check("phase idle", 21'(phase), 21'h0);
        initiator = 1'h0;
        go(5'h10);
        go(5'h02);
        peer.send({SLEC_U_AR, 8'h04}, 0);
        seen("not third", 20'h0_9028);
        initiator = 1'h1;
        go(5'h10);
        go(5'h01);
        peer.send({SLEC_U_AU2, 8'h24}, 0);
        seen("second", 20'h0);
        go(5'h04);
        peer.send({SLEC_U_DT, 8'h24}, 0);
        seen("not response", 20'h0_9034);
        go(5'h10);
        go(5'h01);
        peer.send({SLEC_U_AU2, 8'h20}, 0);
        seen("identity", 20'h0_8044);
    endtask : t_seq
    task automatic t_timeout();
        int n;
        n = 0;
        go(5'h10);
        go(5'h01);
        while (res_valid !== 1'h1 && n < 40)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("wait", 21'(n >= 17 && n <= 22), 21'h1);
        seen("timeout", 20'h0_7034);
    endtask : t_timeout
    task automatic t_impl();
        impl_valid = 1'h1;
        impl_reason = 8'h85;
        impl_sub = 8'h10;
        @(negedge sys_clk);
        check("own code", 21'({res_valid, res.reason, res.sub_reason}), 21'h1_8510);
        impl_reason = 8'h20;
        @(negedge sys_clk);
        impl_valid = 1'h0;
        check("no code", 21'({res_valid, res.reason, res.sub_reason}), 21'h1_7f7f);
    endtask : t_impl
    // hang guard
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    // main sequence
    initial
    begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'h0;
        @(negedge sys_clk);
        check("reset", {res_valid, res}, 21'h0);
        t_events();
        t_table();
        t_setup();
        t_seq();
        t_timeout();
        t_impl();
        end_of_test();
    end
endmodule : slec_classifier_tb
`default_nettype wire
